// ### hdl/scr_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * configuration and identification register group.
 * Assumes the includer runs on a 40 MHz core clock.
 */
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// Register offsets on the serial port (15-bit address)
`define SCR_ADDR_IFCFG     15'h0000
`define SCR_ADDR_PWR       15'h0002
`define SCR_ADDR_CLASS     15'h0003
`define SCR_ADDR_PART_LO   15'h0004
`define SCR_ADDR_PART_HI   15'h0005
`define SCR_ADDR_MAKER_LO  15'h000C
`define SCR_ADDR_MAKER_HI  15'h000D
`define SCR_ADDR_STREAM    15'h0010

// Field positions
`define SCR_SRST_BIT       7
`define SCR_ASCEND_BIT     5
`define SCR_SDO_BIT        4
`define SCR_HOLD_BIT       0
`define SCR_MODE_MSB       1
`define SCR_MODE_PDN       2'h3

// Reset values
`define SCR_RST_IFCFG      8'h30
`define SCR_RST_PWR        8'h00
`define SCR_RST_CLASS_HI   4'h0
`define SCR_RST_STREAM     8'h00

// Serial frame layout
`define SCR_INSTR_LAST     4'hF
`define SCR_BYTE_LAST      4'h7

// Soft reset timing
`define SCR_CLK_PERIOD_PS  25000
`define SCR_SRST_TIME_NS   750
`define SCR_SRST_CYC       ((`SCR_SRST_TIME_NS * 1000) / `SCR_CLK_PERIOD_PS)
`define SCR_SRST_PIPE      2
`define SCR_SRST_HOLD      (`SCR_SRST_CYC - `SCR_SRST_PIPE)

`endif

// ### hdl/scr_pkg.sv
/*
 * Types of the configuration and identification register group.
 * Assumes scr_defines.svh is compiled alongside for the numbers.
 */
package scr_pkg;

   typedef enum logic [1:0] {
      ST_BLOCK,
      ST_INSTR,
      ST_DATA
   } scr_phase_t;

   typedef struct packed {
      logic [7:0] ifcfg;
      logic [7:0] pwr;
      logic [3:0] class_hi;
      logic [7:0] stream;
   } scr_regs_t;

   typedef struct packed {
      logic       sclk_s1;
      logic       sclk_s2;
      logic       sclk_d;
      logic       cs_b_s1;
      logic       cs_b_s2;
      logic       sdi_s1;
      logic       sdi_s2;
      scr_phase_t phase;
      logic [3:0] bitcnt;
      logic [15:0] shreg;
      logic [14:0] addr;
      logic       rd;
      logic [7:0] tx;
      logic       sdo;
      logic       srst_go;
      logic       pdn;
      scr_regs_t  regs;
   } scr_state_t;

   typedef struct packed {
      logic [7:0] count;
      logic       busy;
   } scr_srst_t;

endpackage

// ### hdl/scr_soft_reset.sv
/*
 * Soft reset sequencer: a start pulse raises busy for a fixed hold time.
 * Assumes a synchronous-released active-low reset and a one-cycle start.
 */
`timescale 1ns/1ps
`include "scr_defines.svh"

module scr_soft_reset
   import scr_pkg::*;
(
   input  wire logic core_clk,    // Core clock
   input  wire logic rst_sync_b,  // Released reset, active low
   input  wire logic start,       // One-cycle request
   output logic      busy         // Chip held in reset
);

   localparam logic [7:0] HOLD = 8'(`SCR_SRST_HOLD);

   scr_srst_t s_r;
   scr_srst_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (start) begin
         s_nxt.busy  = 1'b1;
         s_nxt.count = HOLD - 8'h01;
      end else if (s_r.busy) begin
         if (s_r.count == 8'h00) begin
            s_nxt.busy = 1'b0;
         end else begin
            s_nxt.count = s_r.count - 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = s_r.busy;

endmodule

// ### hdl/scr_top.sv
/*
 * Configuration and identification register group behind a four-wire
 * serial port: frame select, serial clock, serial in, dedicated serial out.
 * Assumes the serial pins are asynchronous to the 40 MHz core clock and
 * the serial clock is well below a quarter of the core clock.
 */
`timescale 1ns/1ps
`include "scr_defines.svh"

module scr_top
   import scr_pkg::*;
#(
   parameter logic [3:0]  CLASS_CODE = 4'hA,    // Arbitrary value
   parameter logic [15:0] PART_CODE  = 16'h5A5A, // Arbitrary value
   parameter logic [15:0] MAKER_CODE = 16'hC3C3  // Arbitrary value
) (
   input  wire logic       core_clk,    // Core clock, 40 MHz
   input  wire logic       rst_b,       // Power-up reset, active low
   input  wire logic       spi_cs_b,    // Frame select, active low
   input  wire logic       spi_sclk,    // Serial clock
   input  wire logic       spi_sdi,     // Serial data in
   output logic            spi_sdo,     // Dedicated serial data out
   output logic [1:0]      op_mode,     // Operating mode field
   output logic            power_down,  // Power down selected
   output logic            chip_reset   // Soft reset in progress
);

   logic [1:0] rst_q;
   logic       rst_sync_b;
   logic       srst_busy;
   scr_state_t s_r;
   scr_state_t s_nxt;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_q[1];

   scr_soft_reset u_srst (
      .core_clk   (core_clk),
      .rst_sync_b (rst_sync_b),
      .start      (s_r.srst_go),
      .busy       (srst_busy)
   );

   function automatic scr_regs_t regs_default();
      scr_regs_t r;
      r.ifcfg    = `SCR_RST_IFCFG;
      r.pwr      = `SCR_RST_PWR;
      r.class_hi = `SCR_RST_CLASS_HI;
      r.stream   = `SCR_RST_STREAM;
      return r;
   endfunction

   function automatic logic [7:0] read_byte(input scr_regs_t r, input logic [14:0] a,
                                            input logic busy);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         `SCR_ADDR_IFCFG: begin
            d = r.ifcfg;
            d[`SCR_SRST_BIT] = busy;
            d[`SCR_SDO_BIT]  = 1'b1;
         end
         `SCR_ADDR_PWR:      d = r.pwr;
         `SCR_ADDR_CLASS:    d = {r.class_hi, CLASS_CODE};
         `SCR_ADDR_PART_LO:  d = PART_CODE[7:0];
         `SCR_ADDR_PART_HI:  d = PART_CODE[15:8];
         `SCR_ADDR_MAKER_LO: d = MAKER_CODE[7:0];
         `SCR_ADDR_MAKER_HI: d = MAKER_CODE[15:8];
         `SCR_ADDR_STREAM:   d = r.stream;
         default:            d = 8'h00;
      endcase
      return d;
   endfunction

   function automatic logic [14:0] step_addr(input scr_regs_t r, input logic [14:0] a);
      logic [14:0] n;
      n = a;
      if (r.stream[`SCR_HOLD_BIT]) begin
         n = a;
      end else if (r.ifcfg[`SCR_ASCEND_BIT]) begin
         n = 15'(a + 15'h0001);
      end else begin
         n = 15'(a - 15'h0001);
      end
      return n;
   endfunction

   always_comb begin
      logic       rise;
      logic       fall;
      logic [15:0] sh;
      logic [7:0] wb;
      logic [14:0] na;
      rise = 1'b0;
      fall = 1'b0;
      sh   = 16'h0000;
      wb   = 8'h00;
      na   = 15'h0000;

      s_nxt         = s_r;
      s_nxt.srst_go = 1'b0;
      s_nxt.sclk_s1 = spi_sclk;
      s_nxt.sclk_s2 = s_r.sclk_s1;
      s_nxt.sclk_d  = s_r.sclk_s2;
      s_nxt.cs_b_s1 = spi_cs_b;
      s_nxt.cs_b_s2 = s_r.cs_b_s1;
      s_nxt.sdi_s1  = spi_sdi;
      s_nxt.sdi_s2  = s_r.sdi_s1;

      rise = s_r.sclk_s2 & ~s_r.sclk_d;
      fall = ~s_r.sclk_s2 & s_r.sclk_d;
      sh   = {s_r.shreg[14:0], s_r.sdi_s2};

      if (s_r.cs_b_s2) begin
         s_nxt.phase  = ST_INSTR;
         s_nxt.bitcnt = 4'h0;
         s_nxt.sdo    = 1'b0;
      end else begin
         case (s_r.phase)
            ST_INSTR: begin
               if (rise) begin
                  s_nxt.shreg = sh;
                  if (s_r.bitcnt == `SCR_INSTR_LAST) begin
                     s_nxt.rd     = sh[15];
                     s_nxt.addr   = sh[14:0];
                     s_nxt.phase  = ST_DATA;
                     s_nxt.bitcnt = 4'h0;
                     s_nxt.tx     = read_byte(s_r.regs, sh[14:0], srst_busy);
                  end else begin
                     s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
                  end
               end
            end
            ST_DATA: begin
               if (rise) begin
                  s_nxt.shreg = sh;
                  if (s_r.bitcnt == `SCR_BYTE_LAST) begin
                     wb = sh[7:0];
                     na = step_addr(s_r.regs, s_r.addr);
                     s_nxt.bitcnt = 4'h0;
                     s_nxt.addr   = na;
                     if (s_r.rd) begin
                        s_nxt.tx = read_byte(s_r.regs, na, srst_busy);
                     end else begin
                        case (s_r.addr)
                           `SCR_ADDR_IFCFG: begin
                              s_nxt.regs.ifcfg = wb;
                              s_nxt.regs.ifcfg[`SCR_SRST_BIT] = 1'b0;
                              s_nxt.regs.ifcfg[`SCR_SDO_BIT]  = 1'b1;
                              s_nxt.srst_go = wb[`SCR_SRST_BIT];
                           end
                           `SCR_ADDR_PWR:    s_nxt.regs.pwr      = wb;
                           `SCR_ADDR_CLASS:  s_nxt.regs.class_hi = wb[7:4];
                           `SCR_ADDR_STREAM: s_nxt.regs.stream   = wb;
                           default:          s_nxt.regs          = s_r.regs;
                        endcase
                     end
                  end else begin
                     s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
                  end
               end
               if (fall && s_r.rd) begin
                  s_nxt.sdo = s_r.tx[7];
                  s_nxt.tx  = {s_r.tx[6:0], 1'b0};
               end
            end
            ST_BLOCK: begin
               s_nxt.sdo = 1'b0;
            end
            default: begin
               s_nxt.phase = ST_BLOCK;
            end
         endcase
      end

      // Whole register set held at defaults; open frame abandoned
      if (srst_busy) begin
         s_nxt.regs   = regs_default();
         s_nxt.phase  = ST_BLOCK;
         s_nxt.bitcnt = 4'h0;
         s_nxt.sdo    = 1'b0;
         s_nxt.rd     = 1'b0;
      end

      s_nxt.pdn = (s_nxt.regs.pwr[`SCR_MODE_MSB:0] == `SCR_MODE_PDN);
   end

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s_r          <= '0;
         s_r.sclk_s1  <= 1'b0;
         s_r.cs_b_s1  <= 1'b1;
         s_r.cs_b_s2  <= 1'b1;
         s_r.phase    <= ST_BLOCK;
         s_r.regs.ifcfg    <= `SCR_RST_IFCFG;
         s_r.regs.pwr      <= `SCR_RST_PWR;
         s_r.regs.class_hi <= `SCR_RST_CLASS_HI;
         s_r.regs.stream   <= `SCR_RST_STREAM;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign spi_sdo    = s_r.sdo;
   assign op_mode    = s_r.regs.pwr[`SCR_MODE_MSB:0];
   assign power_down = s_r.pdn;
   assign chip_reset = srst_busy;

endmodule

// ### verif/scr_top_assertions.sv
/* Port checker for the configuration register group top.
   Assumes one 40 MHz core clock and the active-low reset rst_b. */
`timescale 1ns/1ps
module scr_top_checker (
   input wire logic       core_clk,   // Core clock
   input wire logic       rst_b,      // Reset, active low
   input wire logic       spi_cs_b,   // Frame select, active low
   input wire logic       spi_sclk,   // Serial clock
   input wire logic       spi_sdi,    // Serial data in
   input wire logic       spi_sdo,    // Serial data out
   input wire logic [1:0] op_mode,    // Mode field
   input wire logic       power_down, // Power down
   input wire logic       chip_reset  // Soft reset busy
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   pdn_set_a: assert property ($rose(op_mode == 2'h3) |=> power_down)
      else $error("power down missing after mode code 3");
   pdn_clear_a: assert property ((op_mode != 2'h3)[*2] |-> !power_down)
      else $error("power down without mode code 3");
   srst_pulse_a: assert property ($rose(chip_reset) |->
      chip_reset[*8] ##20 chip_reset ##1 !chip_reset)
      else $error("soft reset length wrong");
   mode_cleared_a: assert property (chip_reset[*3] |-> op_mode == 2'h0 && !power_down)
      else $error("mode not cleared by soft reset");
   srst_frame_a: assert property ($rose(chip_reset) |-> !spi_cs_b)
      else $error("soft reset outside a frame");
   srst_clean_a: assert property ($fell(chip_reset) |-> !chip_reset[*8])
      else $error("soft reset retriggered by itself");
   sdo_idle_a: assert property (spi_cs_b[*6] |-> !spi_sdo)
      else $error("serial out active between frames");
   sdo_launch_a: assert property ($changed(spi_sdo) |-> !spi_sclk || spi_cs_b)
      else $error("serial out changed while clock high");
   mode_steady_a: assert property ((spi_cs_b && !chip_reset)[*8] |-> $stable(op_mode))
      else $error("mode changed without a frame");

   cover property ($rose(chip_reset));
   cover property ($rose(power_down));
   cover property ($changed(spi_sdo) && !spi_cs_b);
endmodule

bind scr_top scr_top_checker u_checker (
   .core_clk(core_clk), .rst_b(rst_b), .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk),
   .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .op_mode(op_mode), .power_down(power_down),
   .chip_reset(chip_reset));

// ### verif/scr_host_model.sv
/* Host master model: mode 0 frames, MSB first, read data on sdo.
   Assumes core_clk paces it; h sets each sclk phase in core cycles. */
`timescale 1ns/1ps
module scr_host_model (
   input  wire logic core_clk, // Timing reference
   input  wire logic sdo,      // Read data from device
   output logic      cs_b,     // Frame select, active low
   output logic      sclk,     // Serial clock, idle low
   output logic      sdi,      // Serial data to device
   output logic [7:0] rd_byte, // Last byte read
   output logic      rd_stb    // High while rd_byte is new
);
   int h = 5;
   initial begin
      cs_b = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
      rd_byte = 8'h00;
      rd_stb = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   task automatic frame(input logic [15:0] ins, input int n, input logic [31:0] wd);
      logic [7:0] r;
      tick(1);
      cs_b = 1'b0;
      for (int i = 0; i < 16 + 8 * n; i++) begin
         sdi = (i < 16) ? ins[15 - i] : wd[47 - i];
         tick(h);
         sclk = 1'b1;
         r = {r[6:0], sdo};
         if (ins[15] && i > 15 && i % 8 == 7) begin
            rd_byte = r;
            rd_stb = 1'b1;
         end
         tick(h);
         sclk = 1'b0;
         rd_stb = 1'b0;
      end
      sdi = ~sdi;
      tick(h);
      cs_b = 1'b1;
      tick(6);
   endtask
endmodule

// ### verif/scr_top_bench.sv
/* Self-checking bench for the configuration register group.
   Assumes the host model drives every serial input of the design. */
`timescale 1ns/1ps
`include "scr_defines.svh"
module scr_top_bench;
   localparam logic [3:0]  CLS = 4'h6;     // Arbitrary value
   localparam logic [15:0] PRT = 16'h6B2E; // Arbitrary value
   localparam logic [15:0] MKR = 16'h4D97; // Arbitrary value
   logic       core_clk;
   logic       rst_b;
   logic       cs_b;
   logic       sclk;
   logic       sdi;
   logic       sdo;
   logic [1:0] op_mode;
   logic       pdn;
   logic       crst;
   logic [7:0] rd_byte;
   logic       rd_stb;
   logic [7:0] exp_q[$];
   integer     seed = 32'h78BA17BA;
   int         mismatches = 0;
   int         checks = 0;
   int         cyc = 0;

   scr_top #(.CLASS_CODE(CLS), .PART_CODE(PRT), .MAKER_CODE(MKR)) DUT (
      .core_clk(core_clk), .rst_b(rst_b), .spi_cs_b(cs_b), .spi_sclk(sclk), .spi_sdi(sdi),
      .spi_sdo(sdo), .op_mode(op_mode), .power_down(pdn), .chip_reset(crst));
   scr_host_model host (.core_clk(core_clk), .sdo(sdo), .cs_b(cs_b), .sclk(sclk),
      .sdi(sdi), .rd_byte(rd_byte), .rd_stb(rd_stb));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      host.frame({1'b0, a}, 1, {d, 24'h000000});
   endtask
   task automatic rd(input logic [14:0] a, input int n, input logic [31:0] e);
      for (int i = 0; i < n; i++) exp_q.push_back(e[31 - 8 * i -: 8]);
      host.frame({1'b1, a}, n, 32'h00000000);
   endtask
   // Each read byte is matched to the oldest expectation, and fails when none is queued
   always @(posedge rd_stb) begin
      if (exp_q.size() == 0)
         check(rd_byte, (rd_byte === 8'h00) ? 8'hFF : 8'h00);
      else
         check(rd_byte, exp_q.pop_front());
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         results();
      end
   end

   initial begin
      logic [7:0] v;
      rst_b = 1'b0;
      repeat (2) @(posedge core_clk);
      #2 rst_b = 1'b1;
      repeat (6) @(posedge core_clk);
      rd(`SCR_ADDR_IFCFG, 1, 32'h30000000);
      check({6'h00, op_mode}, 8'h00);
      rd(`SCR_ADDR_PWR, 4, {8'h00, 4'h0, CLS, PRT[7:0], PRT[15:8]});
      rd(`SCR_ADDR_STREAM, 1, 32'h00000000);
      repeat (6) begin
         v = $random(seed);
         host.h = v[2] ? 9 : 5;
         v[1] = v[0];
         wr(`SCR_ADDR_PWR, v);
         check({6'h00, op_mode}, {6'h00, v[1:0]});
         check({7'h00, pdn}, {7'h00, v[0]});
         rd(`SCR_ADDR_PWR, 1, {v, 24'h000000});
         wr(`SCR_ADDR_CLASS, v);
         rd(`SCR_ADDR_CLASS, 1, {v[7:4], CLS, 24'h000000});
      end
      // Descending stream across an unmapped address
      wr(`SCR_ADDR_IFCFG, 8'h4F);
      rd(`SCR_ADDR_IFCFG, 1, 32'h5F000000);
      rd(`SCR_ADDR_MAKER_HI, 3, {MKR[15:8], MKR[7:0], 16'h0000});
      // Address hold overrides direction
      host.h = 5;
      wr(`SCR_ADDR_STREAM, 8'hFF);
      rd(`SCR_ADDR_STREAM, 2, 32'hFFFF0000);
      host.frame({1'b0, `SCR_ADDR_PWR}, 3, 32'h03002B00);
      rd(`SCR_ADDR_PWR, 1, 32'h2B000000);
      check({6'h00, op_mode}, 8'h03);
      // Soft reset restores every register
      wr(`SCR_ADDR_IFCFG, 8'h80);
      check({7'h00, crst}, 8'h01);
      for (int i = 0; i < 30 && crst; i++) @(posedge core_clk);
      #2;
      check({7'h00, crst}, 8'h00);
      check({6'h00, op_mode}, 8'h00);
      check({7'h00, pdn}, 8'h00);
      rd(`SCR_ADDR_IFCFG, 1, 32'h30000000);
      rd(`SCR_ADDR_PWR, 2, {8'h00, 4'h0, CLS, 16'h0000});
      rd(`SCR_ADDR_STREAM, 1, 32'h00000000);
      check(8'(exp_q.size()), 8'h00);
      results();
   end
endmodule
